// File: ssp_pkg.sv
// Constants shared by the synchronous serial shift port.
package ssp_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_MODE_A   = 5'h00;
    localparam logic [4:0] OFS_MODE_B   = 5'h04;
    localparam logic [4:0] OFS_STATUS   = 5'h08;
    localparam logic [4:0] OFS_TX_BUF   = 5'h0C;
    localparam logic [4:0] OFS_RX_BUF   = 5'h10;
    localparam logic [4:0] OFS_BAUD_DIV = 5'h14;

    // ------------------------------------------------------------------
    // Mode control a fields
    // ------------------------------------------------------------------
    localparam int BIT_ORDER_POS  = 7;
    localparam int CHAR_LEN_HI    = 3;
    localparam int CHAR_LEN_LO    = 2;
    localparam int CLK_SOURCE_POS = 1;
    localparam int SYNC_MODE_POS  = 0;

    // ------------------------------------------------------------------
    // Mode control b fields
    // ------------------------------------------------------------------
    localparam int CLK_OUT_EN_POS  = 7;
    localparam int DATA_OUT_EN_POS = 6;
    localparam int ERR_CLEAR_POS   = 5;
    localparam int RX_EN_POS       = 4;
    localparam int TX_EN_POS       = 3;
    localparam int RX_IRQ_EN_POS   = 2;
    localparam int TC_IRQ_EN_POS   = 1;
    localparam int TE_IRQ_EN_POS   = 0;

    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int OVERRUN_POS  = 4;
    localparam int RX_FULL_POS  = 2;
    localparam int TX_DONE_POS  = 1;
    localparam int TX_EMPTY_POS = 0;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  MODE_A_RST   = 8'h00;
    localparam logic [7:0]  MODE_B_RST   = 8'h00;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0001;
    localparam logic [3:0]  CHAR_LEN_MIN = 4'h5;

    typedef enum logic [1:0] {
        SSP_TX_IDLE,
        SSP_TX_WAIT,
        SSP_TX_SHIFT
    } ssp_tx_state_t;

endpackage

// File: ssp_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module ssp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // ssp_sync

// File: ssp_baud.sv
// Dedicated baud tick generator for the internal shift clock.
`timescale 1ns/1ps
module ssp_baud #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    // Control
    input  wire logic             run_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    // Tick out
    output logic                  tick_o
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    // A zero divisor behaves as one so the tick never stops while running.
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run_i) begin
            cnt_d = '0;
        end else if (cnt_q + 1'b1 >= divisor_i) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule // ssp_baud

// File: ssp_top.sv
// Synchronous serial shift port with Avalon-MM register access.
`timescale 1ns/1ps
module ssp_top
    import ssp_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock, reset and enable
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Serial pins
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_o,
    input  wire logic        serial_in_pin_i,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe_o,
    // Interrupt requests
    output logic             rx_irq_o,
    output logic             tx_irq_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] bit_index(input logic [3:0] cnt,
                                             input logic [3:0] len,
                                             input logic       msb_first);
        logic [3:0] idx;
        idx = msb_first ? (len - 4'h1 - cnt) : cnt;
        return idx[2:0];
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]       mode_a_q, mode_a_d;
    logic [7:0]       mode_b_q, mode_b_d;
    logic [DIV_W-1:0] baud_q, baud_d;
    logic [7:0]       tx_buf_q, tx_buf_d;
    logic [7:0]       rx_buf_q, rx_buf_d;
    logic             tx_empty_q, tx_empty_d;
    logic             tx_done_q, tx_done_d;
    logic             rx_full_q, rx_full_d;
    logic             overrun_q, overrun_d;
    logic             ack_q, ack_d;
    logic [31:0]      rdata_q, rdata_d;
    ssp_tx_state_t    tx_st_q, tx_st_d;
    logic [7:0]       tx_sh_q, tx_sh_d;
    logic [3:0]       tx_cnt_q, tx_cnt_d;
    logic             out_q, out_d;
    logic             sclk_q, sclk_d;
    logic [7:0]       rx_sh_q, rx_sh_d;
    logic [3:0]       rx_cnt_q, rx_cnt_d;
    logic             ext_prev_q, ext_prev_d;
    logic             ext_clk, ser_in, tick;
    logic             accept, wr_tx, rd_rx, tx_load, tx_finish, rx_done;
    logic             sync_on, ext_sel, msb_first, rise_ev, fall_ev;
    logic [3:0]       char_len;
    logic [7:0]       len_mask;

    // ------------------------------------------------------------------
    // Pin synchronisers and baud generator
    // ------------------------------------------------------------------
    ssp_sync #(.WIDTH(2)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .async_i  ({serial_clock_pin_i, serial_in_pin_i}),
        .sync_o   ({ext_clk, ser_in})
    );

    ssp_baud #(.DIV_W(DIV_W)) u_baud (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .run_i     (sync_on && !ext_sel),
        .divisor_i (baud_q),
        .tick_o    (tick)
    );

    // ------------------------------------------------------------------
    // Mode decode and shift clock edges
    // ------------------------------------------------------------------
    assign sync_on   = mode_a_q[SYNC_MODE_POS];
    assign ext_sel   = mode_a_q[CLK_SOURCE_POS];
    assign msb_first = mode_a_q[BIT_ORDER_POS];
    assign char_len  = CHAR_LEN_MIN
                     + {2'b00, mode_a_q[CHAR_LEN_HI:CHAR_LEN_LO]};
    assign len_mask  = 8'hFF >> (4'h8 - char_len);

    // External edges come from the second flop and a delayed copy of it.
    // Internal edges: one baud tick toggles the clock, so it runs at half
    // the tick rate, and only while the transmitter has work.
    always_comb begin
        rise_ev = 1'b0;
        fall_ev = 1'b0;
        if (sync_on) begin
            if (ext_sel) begin
                rise_ev = ext_clk && !ext_prev_q;
                fall_ev = !ext_clk && ext_prev_q;
            end else begin
                rise_ev = tick && !sclk_q;
                fall_ev = tick && sclk_q
                        && (tx_st_q != SSP_TX_IDLE);
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------------
    // Every access waits one cycle so the read data come from a flop.
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign accept = (avs_read_i || avs_write_i) && ack_q;
    assign wr_tx  = accept && avs_write_i && avs_address_i == OFS_TX_BUF;
    assign rd_rx  = accept && avs_read_i && avs_address_i == OFS_RX_BUF;

    always_comb begin
        ack_d      = (avs_read_i || avs_write_i) && !ack_q;
        rdata_d    = rdata_q;
        mode_a_d   = mode_a_q;
        mode_b_d   = mode_b_q;
        baud_d     = baud_q;
        tx_buf_d   = tx_buf_q;
        rx_buf_d   = rx_buf_q;
        tx_empty_d = tx_empty_q;
        tx_done_d  = tx_done_q;
        rx_full_d  = rx_full_q;
        overrun_d  = overrun_q;
        if (avs_read_i && !ack_q) begin
            rdata_d = 32'h0;
            if (avs_address_i == OFS_MODE_A) begin
                rdata_d[7:0] = mode_a_q;
            end else if (avs_address_i == OFS_MODE_B) begin
                rdata_d[7:0] = mode_b_q | (8'h01 << ERR_CLEAR_POS);
            end else if (avs_address_i == OFS_STATUS) begin
                rdata_d[OVERRUN_POS]  = overrun_q;
                rdata_d[RX_FULL_POS]  = rx_full_q;
                rdata_d[TX_DONE_POS]  = tx_done_q;
                rdata_d[TX_EMPTY_POS] = tx_empty_q;
            end else if (avs_address_i == OFS_RX_BUF) begin
                rdata_d[7:0] = rx_buf_q;
            end else if (avs_address_i == OFS_BAUD_DIV) begin
                rdata_d[DIV_W-1:0] = baud_q;
            end
        end
        if (accept && avs_write_i) begin
            if (avs_address_i == OFS_MODE_A) begin
                mode_a_d = avs_writedata_i[7:0];
            end else if (avs_address_i == OFS_MODE_B) begin
                mode_b_d = avs_writedata_i[7:0];
                if (!avs_writedata_i[ERR_CLEAR_POS]) begin
                    overrun_d = 1'b0;
                end
            end else if (avs_address_i == OFS_TX_BUF) begin
                tx_buf_d = avs_writedata_i[7:0];
            end else if (avs_address_i == OFS_BAUD_DIV) begin
                baud_d = avs_writedata_i[DIV_W-1:0];
            end
        end
        if (wr_tx) begin
            tx_empty_d = 1'b0;
            tx_done_d  = 1'b0;
        end
        if (rd_rx) begin
            rx_full_d = 1'b0;
        end
        // Hardware sets come last so they win over software clears.
        if (tx_load) begin
            tx_empty_d = 1'b1;
        end
        if (tx_finish && !tx_load) begin
            tx_done_d = 1'b1;
        end
        if (rx_done) begin
            if (rx_full_q) begin
                overrun_d = 1'b1;
            end else begin
                rx_buf_d  = rx_sh_d & len_mask;
                rx_full_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q      <= 1'b0;
            rdata_q    <= 32'h0;
            mode_a_q   <= MODE_A_RST;
            mode_b_q   <= MODE_B_RST;
            baud_q     <= DIV_W'(BAUD_DIV_RST);
            tx_buf_q   <= 8'h00;
            rx_buf_q   <= 8'h00;
            tx_empty_q <= 1'b1;
            tx_done_q  <= 1'b0;
            rx_full_q  <= 1'b0;
            overrun_q  <= 1'b0;
        end else if (ce_i) begin
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
            mode_a_q   <= mode_a_d;
            mode_b_q   <= mode_b_d;
            baud_q     <= baud_d;
            tx_buf_q   <= tx_buf_d;
            rx_buf_q   <= rx_buf_d;
            tx_empty_q <= tx_empty_d;
            tx_done_q  <= tx_done_d;
            rx_full_q  <= rx_full_d;
            overrun_q  <= overrun_d;
        end
    end

    assign avs_readdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Transmitter and internal clock
    // ------------------------------------------------------------------
    // Either order of enable and buffer write meets in this one condition.
    assign tx_load = sync_on && mode_b_q[TX_EN_POS] && !tx_empty_q
                   && (tx_st_q == SSP_TX_IDLE
                       || (tx_st_q == SSP_TX_SHIFT && tx_finish));
    assign tx_finish = tx_st_q == SSP_TX_SHIFT && rise_ev
                     && tx_cnt_q == char_len;

    always_comb begin
        tx_st_d    = tx_st_q;
        tx_sh_d    = tx_sh_q;
        tx_cnt_d   = tx_cnt_q;
        out_d      = out_q;
        ext_prev_d = ext_clk;
        sclk_d     = sclk_q;
        if (!ext_sel && (rise_ev || fall_ev)) begin
            sclk_d = !sclk_q;
        end
        if (!sync_on) begin
            tx_st_d = SSP_TX_IDLE;
            sclk_d  = 1'b1;
        end else begin
            case (tx_st_q)
                SSP_TX_IDLE: begin
                    if (tx_load) begin
                        tx_st_d  = SSP_TX_WAIT;
                        tx_sh_d  = tx_buf_q;
                        tx_cnt_d = 4'h0;
                    end
                end
                SSP_TX_WAIT: begin
                    if (fall_ev) begin
                        out_d    = tx_sh_q[bit_index(4'h0, char_len,
                                                     msb_first)];
                        tx_cnt_d = 4'h1;
                        tx_st_d  = SSP_TX_SHIFT;
                    end
                end
                SSP_TX_SHIFT: begin
                    if (tx_finish) begin
                        tx_st_d = tx_load ? SSP_TX_WAIT
                                          : SSP_TX_IDLE;
                        if (tx_load) begin
                            tx_sh_d  = tx_buf_q;
                            tx_cnt_d = 4'h0;
                        end
                    end else if (fall_ev) begin
                        out_d    = tx_sh_q[bit_index(tx_cnt_q, char_len,
                                                     msb_first)];
                        tx_cnt_d = tx_cnt_q + 4'h1;
                    end
                end
                default: begin
                    tx_st_d = SSP_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_st_q    <= SSP_TX_IDLE;
            tx_sh_q    <= 8'h00;
            tx_cnt_q   <= 4'h0;
            out_q      <= 1'b1;
            sclk_q     <= 1'b1;
            ext_prev_q <= 1'b1;
        end else if (ce_i) begin
            tx_st_q    <= tx_st_d;
            tx_sh_q    <= tx_sh_d;
            tx_cnt_q   <= tx_cnt_d;
            out_q      <= out_d;
            sclk_q     <= sclk_d;
            ext_prev_q <= ext_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    // With the internal clock the receiver only sees rising edges while the
    // transmitter clocks, so a halted transmitter freezes it mid-character.
    assign rx_done = sync_on && mode_b_q[RX_EN_POS] && rise_ev
                   && rx_cnt_q + 4'h1 == char_len;

    always_comb begin
        rx_sh_d  = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        if (!sync_on || !mode_b_q[RX_EN_POS]) begin
            rx_cnt_d = 4'h0;
        end else if (rise_ev) begin
            rx_sh_d[bit_index(rx_cnt_q, char_len, msb_first)] = ser_in;
            rx_cnt_d = rx_done ? 4'h0 : rx_cnt_q + 4'h1;
        end
    end

    // The completing bit is written into the shift register in the same
    // cycle as the buffer copy, so the copy takes it from the next value.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_sh_q  <= 8'h00;
            rx_cnt_q <= 4'h0;
        end else if (ce_i) begin
            rx_sh_q  <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Pins and interrupts
    // ------------------------------------------------------------------
    assign serial_clock_pin_o    = sclk_q;
    assign serial_clock_pin_oe_o = sync_on && !ext_sel
                                 && mode_b_q[CLK_OUT_EN_POS];
    assign serial_out_pin_o      = out_q;
    assign serial_out_pin_oe_o   = mode_b_q[DATA_OUT_EN_POS];
    assign rx_irq_o = mode_b_q[RX_IRQ_EN_POS] && rx_full_q;
    assign tx_irq_o = (mode_b_q[TE_IRQ_EN_POS] && tx_empty_q)
                    || (mode_b_q[TC_IRQ_EN_POS] && tx_done_q);

endmodule // ssp_top

// File: ssp_chk.sv
// Assertion checker for the synchronous serial shift port.
`timescale 1ns/1ps
module ssp_chk
    import ssp_pkg::*;
(
    // Clock, reset and register bus
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    // Pin and interrupt outputs
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe_o,
    input wire logic        rx_irq_o,
    input wire logic        tx_irq_o
);
    // ------------------------------------------------------------------
    // Shadow copies of the control registers
    // ------------------------------------------------------------------
    logic [7:0]  ma_q, mb_q;
    logic [15:0] dv_q;
    logic        wr_ok, rd_rx;
    assign wr_ok = avs_write_i && !avs_waitrequest_o;
    assign rd_rx = avs_read_i && !avs_waitrequest_o
                   && avs_address_i == OFS_RX_BUF;
    // The shadows update on the same edge as the port's own registers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ma_q <= MODE_A_RST;
            mb_q <= MODE_B_RST;
            dv_q <= BAUD_DIV_RST;
        end else if (wr_ok) begin
            if (avs_address_i == OFS_MODE_A) ma_q <= avs_writedata_i[7:0];
            if (avs_address_i == OFS_MODE_B) mb_q <= avs_writedata_i[7:0];
            if (avs_address_i == OFS_BAUD_DIV) dv_q <= avs_writedata_i[15:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_oe_ext; ma_q[CLK_SOURCE_POS] |-> !serial_clock_pin_oe_o;
    endproperty
    a_oe_ext: assert property (p_oe_ext) else $error("clock oe on");
    property p_clk_int; $fell(serial_clock_pin_o) |-> !ma_q[CLK_SOURCE_POS];
    endproperty
    a_clk_int: assert property (p_clk_int) else $error("ext clk");
    property p_clk_tx; $fell(serial_clock_pin_o) |-> mb_q[TX_EN_POS];
    endproperty
    a_clk_tx: assert property (p_clk_tx) else $error("clock idle");
    property p_half; $fell(serial_clock_pin_o) && dv_q == 16'h0004
        |-> !serial_clock_pin_o [*4] ##1 serial_clock_pin_o; endproperty
    a_half: assert property (p_half) else $error("clock phase");
    property p_rx_irq; rx_irq_o |-> mb_q[RX_IRQ_EN_POS]; endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq");
    property p_tx_irq; tx_irq_o |-> mb_q[TE_IRQ_EN_POS] || mb_q[TC_IRQ_EN_POS];
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq");
    property p_rd_clr; rd_rx && mb_q[RX_IRQ_EN_POS] |=> !rx_irq_o; endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("rx full kept");
    property p_wr_clr; wr_ok && avs_address_i == OFS_TX_BUF
        && !mb_q[TX_EN_POS] |=> !tx_irq_o; endproperty
    a_wr_clr: assert property (p_wr_clr) else $error("tx empty kept");
endmodule // ssp_chk
bind ssp_top ssp_chk u_ssp_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o)
);

// File: ssp_peer.sv
// Behavioural serial peer: external clock source, data source and sink.
`timescale 1ns/1ps
module ssp_peer (
    // Control and observation
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] data_i,
    input  wire logic       dev_out_i,
    // Pins and results
    output logic            sck_o,
    output logic            sdi_o,
    output logic [7:0]      got_o,
    output logic            done_o
);
    logic ext_q = 1'b0;
    logic bit_q = 1'b0;
    // Outside its own frames the peer echoes the port's output back.
    assign sdi_o = ext_q ? bit_q : dev_out_i;
    initial begin
        sck_o = 1'b1;
        got_o = 8'h00;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (run_i) begin
                ext_q <= 1'b1;
                for (int i = 0; i < 8; i++) begin
                    repeat (8) @(posedge clk_i);
                    sck_o <= 1'b0;
                    bit_q <= data_i[i];
                    repeat (8) @(posedge clk_i);
                    sck_o <= 1'b1;
                    got_o[i] <= dev_out_i;
                end
                repeat (8) @(posedge clk_i);
                ext_q <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule // ssp_peer

// File: testbench.sv
// Self-checking testbench for the synchronous serial shift port.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
$display("Error at %0t: got %0h exp %0h", $time, g, e); end end
module testbench
    import ssp_pkg::*;
;
    logic        clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        run = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [7:0]  pbyte = 8'h00, got;
    logic        wreq, sck, sdi, sck_o, sck_oe, sdo, sdo_oe;
    logic        rx_irq, tx_irq, pdone;
    int          n_fail = 0, tests_run = 0;
    initial forever #10 clk = ~clk;
    ssp_top u_ssp_top (
        .clk_i(clk), .resetn_i(resetn), .ce_i(1'b1),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .serial_clock_pin_i(sck),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
        .serial_in_pin_i(sdi), .serial_out_pin_o(sdo),
        .serial_out_pin_oe_o(sdo_oe), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq)
    );
    ssp_peer u_ssp_peer (
        .clk_i(clk), .run_i(run), .data_i(pbyte), .dev_out_i(sdo),
        .sck_o(sck), .sdi_o(sdi), .got_o(got), .done_o(pdone)
    );
    // The request holds until waitrequest is seen low at a rising edge.
    // The closing half cycle only lets outputs settle before compares.
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        if (n >= 100) n_fail++;
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rdc(OFS_STATUS, 32'h01);
        rdc(5'h18, 32'h0);
        bus(1'b1, OFS_BAUD_DIV, 32'h4);
        rdc(OFS_BAUD_DIV, 32'h4);
        bus(1'b1, OFS_MODE_A, 32'h01);
        bus(1'b1, OFS_MODE_B, 32'hD5);
        `CHK(tx_irq, 1'b1)
        `CHK(sck_oe, 1'b1)
        rdc(OFS_STATUS, 32'h01);
        bus(1'b1, OFS_TX_BUF, 32'h15);
        `CHK(tx_irq, 1'b0)
        rdc(OFS_STATUS, 32'h00);
        bus(1'b1, OFS_MODE_B, 32'hDD);
        rdc(OFS_STATUS, 32'h01);
        wait (rx_irq === 1'b1);
        rdc(OFS_STATUS, 32'h07);
        rdc(OFS_RX_BUF, 32'h15);
        rdc(OFS_STATUS, 32'h03);
        `CHK(rx_irq, 1'b0)
        bus(1'b1, OFS_MODE_B, 32'hDE);
        bus(1'b1, OFS_TX_BUF, 32'h0A);
        wait (rx_irq === 1'b1);
        bus(1'b1, OFS_TX_BUF, 32'h1B);
        wait (tx_irq === 1'b1);
        rdc(OFS_STATUS, 32'h17);
        rdc(OFS_RX_BUF, 32'h0A);
        bus(1'b1, OFS_MODE_B, 32'h00);
        rdc(OFS_STATUS, 32'h03);
        rdc(OFS_MODE_B, 32'h20);
        bus(1'b1, OFS_MODE_A, 32'h0F);
        bus(1'b1, OFS_MODE_B, 32'hD8);
        `CHK(sck_oe, 1'b0)
        bus(1'b1, OFS_TX_BUF, 32'hA5);
        @(posedge clk);
        pbyte <= 8'h3C;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        wait (pdone === 1'b1);
        `CHK(got, 8'hA5)
        `CHK(sdo_oe, 1'b1)
        rdc(OFS_RX_BUF, 32'h3C);
        close_out();
    end
endmodule // testbench
